/* design/lrr_map.vh */
// Holds the port addresses, sequence lengths, reserved-bit masks and timer figures
// of the legacy register readback block.
// Assumes a byte-wide I/O port strobe interface from the host side.
`ifndef LRR_MAP_VH
`define LRR_MAP_VH

// ==========================================================================
// Port addresses.
// ==========================================================================
`define LRR_PORT_DMA_LO      8'h08
`define LRR_PORT_IRQ_MASTER  8'h20
`define LRR_PORT_TMR0        8'h40
`define LRR_PORT_TMR2        8'h42
`define LRR_PORT_RTC_IDX     8'h70
`define LRR_PORT_IRQ_SLAVE   8'ha0
`define LRR_PORT_DMA_HI      8'hd0

// ==========================================================================
// Sequence lengths.
// ==========================================================================
`define LRR_IRQ_SEQ_LEN      4'hc
`define LRR_TMR_SEQ_LEN      3'h7

// ==========================================================================
// Reserved-bit forcing: value = (raw & keep) | set.
// ==========================================================================
`define LRR_W2_KEEP          8'hf8
`define LRR_W4_KEEP          8'h12
`define LRR_OW2_KEEP         8'he7
`define LRR_OW3_KEEP         8'h47
`define LRR_OW3_SET          8'h08
`define LRR_OW3_MIRROR_SRC   6
`define LRR_OW3_MIRROR_DST   5

// ==========================================================================
// Timer figures, in microseconds; clock rate in MHz.
// ==========================================================================
`define LRR_TICK_SHORT_US    13500
`define LRR_TICK_NORMAL_US   54600
`define LRR_CLK_MHZ          250

`endif

/* design/lrr_readback.v */
// Legacy register readback block: alternate access mode read paths for
// write-only interrupt controller, timer and RTC index registers, and write
// paths into read-only DMA status and current address/count registers.
// Assumes single-cycle I/O read and write strobes from the host port decoder,
// and that the legacy units present their shadowed words on plain inputs.
//
// Operation
// - Alternate mode makes write-only registers readable and read-only ones writable.
// - Port 20h reads one to six give master init words two-four, operation words.
// - Port 20h reads seven to twelve give the slave controller's same six words.
// - Port 40h gives counter 0 status, base low/high, two zero bytes, then counter 2 base.
// - Port 42h read returns counter 2 status byte in alternate mode.
// - Port 70h read returns NMI gate in bit 7, RTC index in bits 6:0.
// - Reserved interrupt controller bits read back as fixed zeros, except operation word three bit 3, which reads as one, and bit 5, which mirrors bit 6.
// - Operation word three bit 5 mirrors bit 6; bits 4:3 read as 01.
// - DMA status ports 08h and D0h accept writes in alternate mode.
// - Normal base writes also load current; alternate mode writes current alone.
// - Entering and leaving after timer reads leaves a 13.5 ms tick until reprogram.
`include "lrr_map.vh"

module lrr_readback (
   input  wire        i_clock,
   input  wire        i_nrst,
   input  wire        i_clk_en,
   input  wire        i_alternate_readback_mode,
   input  wire        i_io_rd,
   input  wire        i_io_wr,
   input  wire [7:0]  i_io_addr,
   input  wire [7:0]  i_io_wdata,
   input  wire        i_timer_reprogram,
   input  wire [47:0] i_master_words,
   input  wire [47:0] i_slave_words,
   input  wire [7:0]  i_tmr0_status,
   input  wire [15:0] i_tmr0_base,
   input  wire [7:0]  i_tmr2_status,
   input  wire [15:0] i_tmr2_base,
   input  wire        i_nmi_gate,
   input  wire [6:0]  i_rtc_index,
   input  wire        i_dma_base_wr,
   input  wire [7:0]  i_dma_cur_sel,
   output reg  [7:0]  o_io_rdata,
   output reg         o_io_rvalid,
   output reg         o_mode_active,
   output reg         o_dma_status_lo_wr,
   output reg         o_dma_status_hi_wr,
   output reg  [7:0]  o_dma_status_data,
   output reg         o_dma_cur_wr,
   output reg  [7:0]  o_dma_cur_sel,
   output reg  [7:0]  o_dma_cur_data,
   output reg         o_timer_short_tick
);

   // ==========================================================================
   // Reset release.
   // ==========================================================================
   reg rst_sync1_reg;
   reg rst_sync2_reg;
   wire rst_n = rst_sync2_reg;

   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync1_reg <= 1'b0;
         rst_sync2_reg <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync2_reg <= rst_sync1_reg;
      end
   end

   // ==========================================================================
   // Word forcing for the interrupt controller readback.
   // ==========================================================================
   // Word order within each 48-bit bundle, low byte first: init two, init three,
   // init four, operation one, operation two, operation three.
   function [7:0] lrr_force;
      input [2:0] slot;
      input [7:0] raw;
      reg   [7:0] v;
      begin
         v = raw;
         case (slot)
            3'h0: v = raw & `LRR_W2_KEEP;
            3'h2: v = raw & `LRR_W4_KEEP;
            3'h4: v = raw & `LRR_OW2_KEEP;
            3'h5: begin
               v = (raw & `LRR_OW3_KEEP) | `LRR_OW3_SET;
               v[`LRR_OW3_MIRROR_DST] = raw[`LRR_OW3_MIRROR_SRC];
            end
            default: v = raw;
         endcase
         lrr_force = v;
      end
   endfunction

   // ==========================================================================
   // Sequence pointers and read mux.
   // ==========================================================================
   reg  [3:0] irq_ptr_reg;
   reg  [2:0] tmr_ptr_reg;
   reg        mode_prev_reg;
   reg        tmr_read_reg;

   wire       mode_enter = i_alternate_readback_mode & ~mode_prev_reg;
   wire       mode_leave = ~i_alternate_readback_mode & mode_prev_reg;
   wire       alt_rd     = i_alternate_readback_mode & i_io_rd;
   wire       rd_irq     = alt_rd & (i_io_addr == `LRR_PORT_IRQ_MASTER);
   wire       rd_tmr0    = alt_rd & (i_io_addr == `LRR_PORT_TMR0);

   wire [3:0] irq_slot   = (irq_ptr_reg < 4'h6) ? irq_ptr_reg : (irq_ptr_reg - 4'h6);
   wire [47:0] irq_bank  = (irq_ptr_reg < 4'h6) ? i_master_words : i_slave_words;
   wire [7:0] irq_raw    = irq_bank[{irq_slot[2:0], 3'h0} +: 8];

   reg  [7:0] tmr_byte;
   always @* begin
      case (tmr_ptr_reg)
         3'h0:    tmr_byte = i_tmr0_status;
         3'h1:    tmr_byte = i_tmr0_base[7:0];
         3'h2:    tmr_byte = i_tmr0_base[15:8];
         3'h5:    tmr_byte = i_tmr2_base[7:0];
         3'h6:    tmr_byte = i_tmr2_base[15:8];
         default: tmr_byte = 8'h00;
      endcase
   end

   reg  [7:0] rd_next;
   reg        rv_next;
   always @* begin
      rd_next = 8'h00;
      rv_next = alt_rd;
      case (i_io_addr)
         `LRR_PORT_IRQ_MASTER: rd_next = lrr_force(irq_slot[2:0], irq_raw);
         `LRR_PORT_TMR0:       rd_next = tmr_byte;
         `LRR_PORT_TMR2:       rd_next = i_tmr2_status;
         `LRR_PORT_RTC_IDX:    rd_next = {i_nmi_gate, i_rtc_index};
         default:              rv_next = 1'b0;
      endcase
   end

   // ==========================================================================
   // Registered state and outputs.
   // ==========================================================================
   always @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_ptr_reg        <= 4'h0;
         tmr_ptr_reg        <= 3'h0;
         mode_prev_reg      <= 1'b0;
         tmr_read_reg       <= 1'b0;
         o_io_rdata         <= 8'h00;
         o_io_rvalid        <= 1'b0;
         o_mode_active      <= 1'b0;
         o_dma_status_lo_wr <= 1'b0;
         o_dma_status_hi_wr <= 1'b0;
         o_dma_status_data  <= 8'h00;
         o_dma_cur_wr       <= 1'b0;
         o_dma_cur_sel      <= 8'h00;
         o_dma_cur_data     <= 8'h00;
         o_timer_short_tick <= 1'b0;
      end else if (i_clk_en) begin
         mode_prev_reg <= i_alternate_readback_mode;
         o_mode_active <= i_alternate_readback_mode;
         o_io_rdata    <= rv_next ? rd_next : 8'h00;
         o_io_rvalid   <= rv_next;

         if (mode_enter) begin
            irq_ptr_reg <= 4'h0;
            tmr_ptr_reg <= 3'h0;
         end else begin
            if (rd_irq)
               irq_ptr_reg <= (irq_ptr_reg == `LRR_IRQ_SEQ_LEN - 4'h1) ? 4'h0
                                                                       : irq_ptr_reg + 4'h1;
            if (rd_tmr0)
               tmr_ptr_reg <= (tmr_ptr_reg == `LRR_TMR_SEQ_LEN - 3'h1) ? 3'h0
                                                                       : tmr_ptr_reg + 3'h1;
         end

         // Timer reads in the mode leave the counter on the short period once the
         // mode is left; only a fresh program by software clears it.
         // A timer read or a mode exit in the same cycle as a reprogram wins,
         // so a save sequence is never lost to a coincident clear.
         if (i_timer_reprogram) begin
            tmr_read_reg       <= 1'b0;
            o_timer_short_tick <= 1'b0;
         end
         if (rd_tmr0 || (alt_rd && i_io_addr == `LRR_PORT_TMR2))
            tmr_read_reg <= 1'b1;
         if (mode_leave && tmr_read_reg)
            o_timer_short_tick <= 1'b1;

         // Status writes pass only in the mode; elsewhere the ports stay read-only.
         o_dma_status_lo_wr <= i_alternate_readback_mode & i_io_wr &
                               (i_io_addr == `LRR_PORT_DMA_LO);
         o_dma_status_hi_wr <= i_alternate_readback_mode & i_io_wr &
                               (i_io_addr == `LRR_PORT_DMA_HI);
         o_dma_status_data  <= i_io_wdata;

         // A base write outside the mode copies into current; inside the mode
         // the current register is loaded on its own, leaving base untouched.
         // Status port writes never strobe a current register.
         o_dma_cur_wr   <= i_io_wr & (i_io_addr != `LRR_PORT_DMA_LO) &
                           (i_io_addr != `LRR_PORT_DMA_HI) &
                           (i_alternate_readback_mode | i_dma_base_wr);
         o_dma_cur_sel  <= i_dma_cur_sel;
         o_dma_cur_data <= i_io_wdata;
      end
   end

endmodule

/* sim/lrr_readback_asserts.sv */
// Concurrent checks on the ports of the legacy register readback block.
// Assumes the host strobes and the internal two-flop reset release of the top.
module lrr_readback_asserts (
   input logic       i_clock, i_nrst, i_clk_en, i_alternate_readback_mode,
   input logic       i_io_rd, i_io_wr, i_timer_reprogram, i_nmi_gate,
   input logic [7:0] i_io_addr, i_io_wdata, i_tmr2_status, o_io_rdata, o_dma_status_data,
   input logic [6:0] i_rtc_index,
   input logic       o_io_rvalid, o_mode_active, o_dma_status_lo_wr, o_dma_status_hi_wr,
   input logic       o_timer_short_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Properties.
   // ==========================================================================
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Both the level and its registered copy must be high, so entry edges are not judged.
   wire in_mode = i_alternate_readback_mode && o_mode_active;
   wire idle_mode = !i_alternate_readback_mode && !o_mode_active;
   wire rd = i_clk_en && i_io_rd;
   wire wr = i_clk_en && i_io_wr;
   AST_TMR2_STATUS: assert property (rd && in_mode && i_io_addr == 8'h42 |=>
      o_io_rvalid && o_io_rdata == $past(i_tmr2_status)) else $error("status read wrong");
   AST_RTC_INDEX: assert property (rd && in_mode && i_io_addr == 8'h70 |=>
      o_io_rdata == {$past(i_nmi_gate), $past(i_rtc_index)}) else $error("index read wrong");
   AST_DMA_LO_WRITE: assert property (wr && in_mode && i_io_addr == 8'h08 |=>
      o_dma_status_lo_wr && o_dma_status_data == $past(i_io_wdata)) else $error("low write");
   AST_DMA_HI_WRITE: assert property (wr && in_mode && i_io_addr == 8'hd0 |=>
      o_dma_status_hi_wr && o_dma_status_data == $past(i_io_wdata)) else $error("high write");
   AST_STATUS_NORMAL: assert property (wr && idle_mode |=>
      !o_dma_status_lo_wr && !o_dma_status_hi_wr) else $error("status written in normal mode");
   AST_READ_REFUSED: assert property (rd && idle_mode |=>
      !o_io_rvalid && o_io_rdata == 8'h00) else $error("read answered in normal mode");
   AST_RVALID_CAUSE: assert property (o_io_rvalid |-> $past(rd))
      else $error("answer without read");
   AST_SHORT_TICK_HOLD: assert property (o_timer_short_tick && !i_timer_reprogram |=>
      o_timer_short_tick) else $error("short tick dropped");
   cover property (rd && in_mode && i_io_addr == 8'h20 ##1 o_io_rvalid);
   cover property (rd && in_mode && i_io_addr == 8'h40 ##1 o_io_rvalid);
   cover property ($rose(o_timer_short_tick));
endmodule

bind lrr_readback lrr_readback_asserts lrr_readback_asserts_i (.*);

/* sim/tb_top.sv */
// Self-checking bench for the legacy register readback block.
// Drives the host port strobes at the falling edge; answers come one cycle on.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clock, i_nrst, i_alternate_readback_mode, i_io_rd, i_io_wr;
   logic        i_timer_reprogram, i_dma_base_wr, i_clk_en = 1'b1, i_nmi_gate = 1'b1;
   logic [6:0]  i_rtc_index = 7'h4b;
   logic [7:0]  i_io_addr, i_io_wdata, i_tmr0_status = 8'h36, i_tmr2_status = 8'hb6;
   logic [7:0]  i_dma_cur_sel = 8'h05;
   logic [15:0] i_tmr0_base = 16'h1234, i_tmr2_base = 16'hfedc;
   logic [47:0] i_master_words = 48'hffff_ffff_ffff, i_slave_words = 48'h35a5_c35a_6996;
   wire  [7:0]  o_io_rdata, o_dma_status_data, o_dma_cur_sel, o_dma_cur_data;
   wire         o_io_rvalid, o_mode_active, o_dma_status_lo_wr, o_dma_status_hi_wr;
   wire         o_dma_cur_wr, o_timer_short_tick;
   int          n_fail = 0, n_checks = 0;

   lrr_readback lrr_readback_i (.*);

   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   // ==========================================================================
   // Access tasks and expected values.
   // ==========================================================================
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [8:0] exp);
      @(negedge i_clock);
      {i_io_rd, i_io_addr} = {1'b1, a};
      @(negedge i_clock);
      chk({o_io_rvalid, o_io_rdata}, exp, "read");
      i_io_rd = 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, d, input logic base, input logic [2:0] exp);
      @(negedge i_clock);
      {i_io_wr, i_io_addr, i_io_wdata, i_dma_base_wr} = {1'b1, a, d, base};
      @(negedge i_clock);
      chk({o_dma_status_lo_wr, o_dma_status_hi_wr, o_dma_cur_wr}, exp, "strobes");
      if (exp[2:1] != 2'b00) chk(o_dma_status_data, d, "status data");
      if (exp[0]) chk({o_dma_cur_sel, o_dma_cur_data}, {i_dma_cur_sel, d}, "current");
      {i_io_wr, i_dma_base_wr} = 2'b00;
   endtask

   // Reserved bits are forced; the mirror bit copies bit 6 of the same word.
   function automatic logic [7:0] pic(input int s, input logic [47:0] w);
      logic [7:0] b;
      b = w[8*s +: 8];
      case (s)
         0: b = b & 8'hf8;
         2: b = b & 8'h12;
         4: b = b & 8'he7;
         5: b = (b & 8'h47) | 8'h08 | {2'b00, b[6], 5'h00};
         default: ;
      endcase
      return b;
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      logic [7:0] e40 [7];
      {i_nrst, i_alternate_readback_mode, i_io_rd, i_io_wr, i_timer_reprogram} = 5'h00;
      {i_dma_base_wr, i_io_addr, i_io_wdata} = 17'h00000;
      repeat (16) @(negedge i_clock);
      chk({o_io_rvalid, o_mode_active, o_timer_short_tick}, 3'b000, "reset");
      i_nrst = 1'b1;
      repeat (3) @(negedge i_clock);
      rd(8'h20, 9'h000);
      wr(8'h08, 8'h5a, 1'b0, 3'b000);
      wr(8'h00, 8'h3c, 1'b1, 3'b001);
      $display("normal mode test done");
      i_alternate_readback_mode = 1'b1;
      repeat (2) @(negedge i_clock);
      for (int k = 0; k < 13; k++)
         rd(8'h20, {1'b1, pic(k % 6, (k % 12) < 6 ? i_master_words : i_slave_words)});
      e40 = '{i_tmr0_status, i_tmr0_base[7:0], i_tmr0_base[15:8], 8'h00, 8'h00,
              i_tmr2_base[7:0], i_tmr2_base[15:8]};
      for (int k = 0; k < 8; k++)
         rd(8'h40, {1'b1, e40[k % 7]});
      rd(8'h42, {1'b1, i_tmr2_status});
      rd(8'h70, {1'b1, i_nmi_gate, i_rtc_index});
      rd(8'h55, 9'h000);
      wr(8'h08, 8'ha5, 1'b0, 3'b100);
      wr(8'hd0, 8'h5a, 1'b0, 3'b010);
      wr(8'h00, 8'hc3, 1'b0, 3'b001);
      $display("readback test done");
      i_alternate_readback_mode = 1'b0;
      repeat (3) @(negedge i_clock);
      chk(o_timer_short_tick, 1'b1, "short tick");
      i_alternate_readback_mode = 1'b1;
      repeat (2) @(negedge i_clock);
      rd(8'h20, {1'b1, pic(0, i_master_words)});
      rd(8'h40, {1'b1, i_tmr0_status});
      @(negedge i_clock) i_timer_reprogram = 1'b1;
      @(negedge i_clock) i_timer_reprogram = 1'b0;
      repeat (2) @(negedge i_clock);
      chk(o_timer_short_tick, 1'b0, "tick restored");
      $display("mode exit test done");
      complete_run();
   end

   initial begin
      repeat (3000) @(posedge i_clock);
      n_fail++;
      complete_run();
   end
endmodule
